// file: inc/tas_flag_if.sv
// Purpose: set/clear/state bundle between control and flag bank
// Assumes: one clock domain
// Notes:   set and clear are one-cycle vectors
interface tas_flag_if;
  import tas_pkg::*;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] flags;

  // control side drives set/clear and reads flags
  modport ctrl (output set_vec, output clr_vec, input flags);
  // bank side stores the flags
  modport bank (input set_vec, input clr_vec, output flags);
endinterface

// file: inc/tas_pkg.sv
// Purpose: shared constants of the alert status logic
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   flag bit positions apply inside each alert byte
package tas_pkg;

  // register offsets
  localparam logic [7:0] TAS_ADDR_FLAGS_LOW  = 8'h10;
  localparam logic [7:0] TAS_ADDR_FLAGS_HIGH = 8'h11;

  // lower alert byte bit positions
  localparam int TAS_LO_CC_CHANGE      = 0;
  localparam int TAS_LO_POWER_CHANGE   = 1;
  localparam int TAS_LO_MSG_RECEIVED   = 2;
  localparam int TAS_LO_RX_HARD_RESET  = 3;
  localparam int TAS_LO_TX_FAILED      = 4;
  localparam int TAS_LO_TX_DISCARDED   = 5;

  // upper alert byte bit positions
  localparam int TAS_HI_BUS_LOW_ALARM  = 0;
  localparam int TAS_HI_FAULT          = 1;
  localparam int TAS_HI_RX_OVERFLOW    = 2;
  localparam int TAS_HI_SINK_DISC      = 3;
  localparam int TAS_HI_CHUNK_START    = 4;
  localparam int TAS_HI_EXT_STATE      = 5;
  localparam int TAS_HI_EXTENDED       = 6;
  localparam int TAS_HI_VENDOR         = 7;

  // reset values and implemented-bit masks
  localparam logic [7:0] TAS_FLAGS_RESET   = 8'h00;
  localparam logic [7:0] TAS_LOW_IMPL_MASK = 8'h3F;  // bits 7..6 live elsewhere
  localparam logic [7:0] TAS_HIGH_W1C_MASK = 8'hA7;  // 7,5,2,1,0 writable
  localparam logic [7:0] TAS_RDATA_UNMAPPED = 8'h00;

endpackage

// file: tb/tas_alert_status_monitor.sv
// Purpose: port checks of the alert status block
// Assumes: one clock, synchronous low reset
// Notes: bound to the top module
module tas_alert_status_monitor
  import tas_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // events and masks
  input wire logic       tx_fail_evt,
  input wire logic       tx_discard_evt,
  input wire logic       rx_overflow_evt,
  input wire logic [7:0] mask_low,
  input wire logic [7:0] mask_high,
  // outputs
  input wire logic       alert_n_o,
  input wire logic       alert_n_oe,
  input wire logic       goodcrc_inhibit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // read requests
  sequence s_rd_hi; reg_rd && reg_addr == TAS_ADDR_FLAGS_HIGH; endsequence
  sequence s_rd_off; reg_rd && reg_addr[7:1] != 7'h08; endsequence
  property p_fail; tx_fail_evt && mask_low[4] |=> alert_n_oe; endproperty
  a_fail: assert property (p_fail) else $error("fail flag kept alert idle");
  property p_disc; tx_discard_evt && mask_low[5] |=> alert_n_oe; endproperty
  a_disc: assert property (p_disc) else $error("discard flag kept alert idle");
  property p_inh; rx_overflow_evt |=> goodcrc_inhibit; endproperty
  a_inh: assert property (p_inh) else $error("overflow gave no inhibit");
  property p_hold; goodcrc_inhibit && !reg_wr |=> goodcrc_inhibit; endproperty
  a_hold: assert property (p_hold) else $error("inhibit dropped unasked");
  property p_rel; mask_low[5:0] == 6'h00 && mask_high == 8'h00 |-> !alert_n_oe; endproperty
  a_rel: assert property (p_rel) else $error("masked flags drive alert");
  property p_drv; alert_n_oe |-> !alert_n_o; endproperty
  a_drv: assert property (p_drv) else $error("alert driven high");
  property p_hi; s_rd_hi |=> reg_rdata[6] == 1'b0 && reg_rdata[3] == 1'b0; endproperty
  a_hi: assert property (p_hi) else $error("fixed zero bits read one");
  property p_off; s_rd_off |=> reg_rdata == 8'h00; endproperty
  a_off: assert property (p_off) else $error("unmapped read not zero");
endmodule
bind tas_alert_status tas_alert_status_monitor i_mon (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .tx_fail_evt, .tx_discard_evt, .rx_overflow_evt, .mask_low, .mask_high, .alert_n_o,
  .alert_n_oe, .goodcrc_inhibit);

// file: tb/tas_tcpm_model.sv
// Purpose: port manager side of the alert wire
// Assumes: pull-up on the open-drain line
// Notes: register access comes from bench tasks
module tas_tcpm_model (
  // alert pin
  input wire logic alert_n_o,
  input wire logic alert_n_oe,
  // resolved level
  output logic     alert_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up wins while nobody drives
  assign alert_line = alert_n_oe ? alert_n_o : 1'b1;
endmodule

// file: tb/test_tas_alert_status.sv
// Purpose: self-checking bench of the alert status block
// Assumes: low flags at 0x10, high at 0x11
// Notes: events are pulsed through one vector
`define CHK(a,b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("wrong value %0t %h %h", $time, a, b); end end
module test_tas_alert_status;
  import tas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sk = 0, ske = 0, ven = 0;
  logic [7:0]  reg_addr = '0, reg_wdata = '0, pw = '0, ml = 8'hFF, mh = 8'hFF, reg_rdata;
  logic [1:0]  c1 = '0, c2 = '0;
  logic [10:0] ev = '0;
  logic        alert_n_o, alert_n_oe, goodcrc_inhibit, alert_line;
  int          failures = 0, num_checks = 0;
  // clock
  always #50 mclk = ~mclk;
  tas_alert_status i_tas_alert_status (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .tx_discard_evt(ev[5]), .tx_fail_evt(ev[4]), .rx_hard_reset_evt(ev[3]), .rx_buffer_load_evt(ev[2]),
    .rx_count_zero_evt(ev[6]), .rx_overflow_evt(ev[7]), .power_status(pw), .cc_line_one_setting(c1),
    .cc_line_two_setting(c2), .seeking_connection(sk), .seeking_connection_alert_enable(ske),
    .vendor_alert_src(ven), .ext_state_evt(ev[8]), .fault_evt(ev[9]), .bus_voltage_low_alarm(ev[10]),
    .mask_low(ml), .mask_high(mh), .alert_n_o, .alert_n_oe, .goodcrc_inhibit);
  tas_tcpm_model i_tas_tcpm_model (.alert_n_o, .alert_n_oe, .alert_line);
  // register and event drivers
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic pulse(logic [10:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= '0;
  endtask
  // scenarios
  task automatic t_low;
    pulse(11'h03C);
    @(posedge mclk);
    pw <= 8'h80;
    c2 <= 2'h1;
    rd(TAS_ADDR_FLAGS_LOW, 8'h3F);
    `CHK(alert_line, 1'b0)
    wr(TAS_ADDR_FLAGS_LOW, 8'h0F);
    rd(TAS_ADDR_FLAGS_LOW, 8'h30);
    wr(TAS_ADDR_FLAGS_LOW, 8'h30);
    rd(8'h20, 8'h00);
    `CHK(alert_line, 1'b1)
  endtask
  task automatic t_seek;
    pulse(11'h040);
    sk <= 1'b1;
    rd(TAS_ADDR_FLAGS_LOW, 8'h00);
    @(posedge mclk);
    ske <= 1'b1;
    sk <= 1'b0;
    rd(TAS_ADDR_FLAGS_LOW, 8'h01);
    wr(TAS_ADDR_FLAGS_LOW, 8'h01);
    @(posedge mclk);
    c1 <= 2'h2;
    rd(TAS_ADDR_FLAGS_LOW, 8'h01);
    wr(TAS_ADDR_FLAGS_LOW, 8'h01);
  endtask
  task automatic t_mask;
    ml <= 8'h00;
    mh <= 8'h00;
    pulse(11'h010);
    #1 `CHK(alert_line, 1'b1)
    rd(TAS_ADDR_FLAGS_LOW, 8'h10);
    wr(TAS_ADDR_FLAGS_LOW, 8'h10);
    ml <= 8'hFF;
    mh <= 8'hFF;
  endtask
  task automatic t_high;
    ven <= 1'b1;
    pulse(11'h700);
    rd(TAS_ADDR_FLAGS_HIGH, 8'hA3);
    `CHK(alert_line, 1'b0)
    wr(TAS_ADDR_FLAGS_HIGH, 8'hFF);
    rd(TAS_ADDR_FLAGS_HIGH, 8'h00);
    @(posedge mclk);
    ven <= 1'b0;
  endtask
  task automatic t_ovf;
    pulse(11'h080);
    #1 `CHK(goodcrc_inhibit, 1'b1)
    wr(TAS_ADDR_FLAGS_HIGH, 8'h04);
    rd(TAS_ADDR_FLAGS_HIGH, 8'h04);
    wr(TAS_ADDR_FLAGS_LOW, 8'h04);
    rd(TAS_ADDR_FLAGS_HIGH, 8'h00);
    `CHK(goodcrc_inhibit, 1'b0)
  endtask
  // verdict
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(TAS_ADDR_FLAGS_HIGH, 8'h00);
    t_low();
    t_seek();
    t_mask();
    t_high();
    t_ovf();
    test_done();
  end
  // watchdog: the scenarios need about sixty cycles, give up after 2000
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule

// file: verilog/tas_alert_status.sv
// Purpose: alert flag registers and open-drain alert pin of a PD port controller
// Assumes: events are one-cycle pulses or levels synchronous to mclk
// Notes:   mask bits are 1 for unmasked; masks live outside this block
// Contract
// - each flag sets on its event and stays latched until the manager clears it.
// - any set and unmasked flag drives the alert pin low.
// - lower bit 5 sets when a transmission is abandoned for an incoming message.
// - lower bit 4 sets when no acknowledgement returns for a sent message.
// - lower bit 3 sets when a hard reset is received from the partner.
// - lower bit 2 sets on receive buffer change, not on count reaching zero.
// - lower bit 1 sets whenever any power status condition changes.
// - lower bit 0 sets when bits 1:0 of either CC setting change.
// - seeking-connection toggles set bit 0 only when its alert enable is 1.
// - upper byte resets to zero; bits 7,5,1,0 clear on 1, bit 2 through its paired release, others read-only.
// - upper bit 6 always reads zero.
// - masked flags still latch but do not pull the pin low.
// - upper bit 3 always reads zero, the device being source only.
// - overflow clears only after 1 written to it and to message-received.
module tas_alert_status
  import tas_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // transmit and receive events
  input  wire logic       tx_discard_evt,
  input  wire logic       tx_fail_evt,
  input  wire logic       rx_hard_reset_evt,
  input  wire logic       rx_buffer_load_evt,
  input  wire logic       rx_count_zero_evt,
  input  wire logic       rx_overflow_evt,
  // status sources
  input  wire logic [7:0] power_status,
  input  wire logic [1:0] cc_line_one_setting,
  input  wire logic [1:0] cc_line_two_setting,
  input  wire logic       seeking_connection,
  input  wire logic       seeking_connection_alert_enable,
  input  wire logic       vendor_alert_src,
  input  wire logic       ext_state_evt,
  input  wire logic       fault_evt,
  input  wire logic       bus_voltage_low_alarm,
  // masks, 1 = unmasked
  input  wire logic [7:0] mask_low,
  input  wire logic [7:0] mask_high,
  // alert pin, open drain
  output logic            alert_n_o,
  output logic            alert_n_oe,
  // receive control
  output logic            goodcrc_inhibit
);

  tas_flag_if fl_lo ();
  tas_flag_if fl_hi ();

  logic [7:0] power_prev_r;
  logic [1:0] cc_one_prev_r;
  logic [1:0] cc_two_prev_r;
  logic       seek_prev_r;
  logic       vendor_prev_r;
  logic       ovf_ack_lo_r;
  logic       ovf_ack_hi_r;
  logic [7:0] reg_rdata_r;
  logic       wr_lo;
  logic       wr_hi;
  logic       ovf_clear;
  logic       pend_lo;
  logic       pend_hi;

  // flag storage
  tas_flag_bank u_lo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .fb    (fl_lo.bank)
  );
  tas_flag_bank u_hi (
    .mclk  (mclk),
    .rst_n (rst_n),
    .fb    (fl_hi.bank)
  );

  // a strobe aimed at one byte offset
  function automatic logic tas_hit(
    input logic       strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && (addr == target);
  endfunction

  // flags to clear on a write-1-to-clear byte; positions outside the
  // writable set are ignored so read-only bits cannot be disturbed
  function automatic logic [7:0] tas_w1c(
    input logic       hit,
    input logic [7:0] data,
    input logic [7:0] writable
  );
    return hit ? (data & writable) : 8'h00;
  endfunction

  // true while any set flag is let through by its mask (1 = unmasked)
  function automatic logic tas_pending(
    input logic [7:0] flags,
    input logic [7:0] unmasked
  );
    return |(flags & unmasked);
  endfunction

  // write decode
  assign wr_lo = tas_hit(reg_wr, reg_addr, TAS_ADDR_FLAGS_LOW);
  assign wr_hi = tas_hit(reg_wr, reg_addr, TAS_ADDR_FLAGS_HIGH);

  // previous values for change detection; they reset to zero, so a level
  // that is already nonzero when reset ends reports one change, which the
  // manager clears during start-up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      power_prev_r  <= 8'h00;
      cc_one_prev_r <= 2'h0;
      cc_two_prev_r <= 2'h0;
      seek_prev_r   <= 1'b0;
      vendor_prev_r <= 1'b0;
    end else begin
      power_prev_r  <= power_status;
      cc_one_prev_r <= cc_line_one_setting;
      cc_two_prev_r <= cc_line_two_setting;
      seek_prev_r   <= seeking_connection;
      vendor_prev_r <= vendor_alert_src;
    end
  end

  // overflow release needs a 1 written to both flags, in either order;
  // a half-done release is forgotten once the flag is gone, so a stale
  // acknowledgement cannot clear the next overflow early
  assign ovf_clear = (ovf_ack_lo_r || (wr_lo && reg_wdata[TAS_LO_MSG_RECEIVED]))
                  && (ovf_ack_hi_r || (wr_hi && reg_wdata[TAS_HI_RX_OVERFLOW]));

  // remember which half of the overflow release has been written
  always_ff @(posedge mclk) begin
    if (!rst_n || ovf_clear || !fl_hi.flags[TAS_HI_RX_OVERFLOW]) begin
      ovf_ack_lo_r <= 1'b0;
      ovf_ack_hi_r <= 1'b0;
    end else begin
      if (wr_lo && reg_wdata[TAS_LO_MSG_RECEIVED]) begin
        ovf_ack_lo_r <= 1'b1;
      end
      if (wr_hi && reg_wdata[TAS_HI_RX_OVERFLOW]) begin
        ovf_ack_hi_r <= 1'b1;
      end
    end
  end

  // lower byte set sources; seeking-connection toggles report only
  // while their alert enable is high
  always_comb begin
    fl_lo.set_vec = 8'h00;
    fl_lo.set_vec[TAS_LO_TX_DISCARDED]  = tx_discard_evt;
    fl_lo.set_vec[TAS_LO_TX_FAILED]     = tx_fail_evt;
    fl_lo.set_vec[TAS_LO_RX_HARD_RESET] = rx_hard_reset_evt;
    fl_lo.set_vec[TAS_LO_MSG_RECEIVED]  = rx_buffer_load_evt;
    fl_lo.set_vec[TAS_LO_POWER_CHANGE]  = (power_status != power_prev_r);
    fl_lo.set_vec[TAS_LO_CC_CHANGE]     = (cc_line_one_setting != cc_one_prev_r)
                                       || (cc_line_two_setting != cc_two_prev_r)
                                       || (seeking_connection_alert_enable
                                           && (seeking_connection != seek_prev_r));
  end

  // write-1-to-clear on the implemented lower bits; rx_count_zero_evt is
  // left unread on purpose, since an emptied buffer is not a new message
  assign fl_lo.clr_vec = tas_w1c(wr_lo, reg_wdata, TAS_LOW_IMPL_MASK);

  // upper byte set sources; bits 6,4,3 never set; the vendor flag takes the
  // rising edge of its source so a clear sticks while the source stays high
  always_comb begin
    fl_hi.set_vec = 8'h00;
    fl_hi.set_vec[TAS_HI_VENDOR]        = vendor_alert_src && !vendor_prev_r;
    fl_hi.set_vec[TAS_HI_EXT_STATE]     = ext_state_evt;
    fl_hi.set_vec[TAS_HI_RX_OVERFLOW]   = rx_overflow_evt;
    fl_hi.set_vec[TAS_HI_FAULT]         = fault_evt;
    fl_hi.set_vec[TAS_HI_BUS_LOW_ALARM] = bus_voltage_low_alarm;
  end

  // w1c on writable bits; overflow only through its paired release
  always_comb begin
    fl_hi.clr_vec = tas_w1c(wr_hi, reg_wdata, TAS_HIGH_W1C_MASK);
    fl_hi.clr_vec[TAS_HI_RX_OVERFLOW] = ovf_clear;
  end

  // registered read data, unmapped reads zero; the value stands until the next read;
  // the read-only upper positions are all fixed zero, so only writable bits pass
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_r <= TAS_RDATA_UNMAPPED;
    end else if (reg_rd) begin
      unique case (reg_addr)
        TAS_ADDR_FLAGS_LOW:  reg_rdata_r <= fl_lo.flags & TAS_LOW_IMPL_MASK;
        TAS_ADDR_FLAGS_HIGH: reg_rdata_r <= fl_hi.flags & TAS_HIGH_W1C_MASK;
        default:             reg_rdata_r <= TAS_RDATA_UNMAPPED;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_r;

  // pending requests per byte; lower bits 7..6 belong elsewhere and never count
  assign pend_lo = tas_pending(fl_lo.flags, mask_low & TAS_LOW_IMPL_MASK);
  assign pend_hi = tas_pending(fl_hi.flags, mask_high);

  // open-drain alert: the pin data is fixed low and only the enable moves,
  // so the line is pulled low while any unmasked flag is set
  assign alert_n_o  = 1'b0;
  assign alert_n_oe = pend_lo || pend_hi;

  // withhold acknowledgements while overflowed
  assign goodcrc_inhibit = fl_hi.flags[TAS_HI_RX_OVERFLOW];

endmodule

// file: verilog/tas_flag_bank.sv
// Purpose: one byte of latched event flags
// Assumes: synchronous active-low reset
// Notes:   a set in the same cycle as a clear wins
module tas_flag_bank
  import tas_pkg::*;
(
  // clock and reset
  input  wire logic   mclk,
  input  wire logic   rst_n,
  // flag bundle
  tas_flag_if.bank    fb
);

  logic [7:0] flags_r;

  // latch until cleared, set beats clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flags_r <= TAS_FLAGS_RESET;
    end else begin
      flags_r <= (flags_r & ~fb.clr_vec) | fb.set_vec;
    end
  end

  assign fb.flags = flags_r;

endmodule
